// ---- hdl/isc_map.svh ----
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH
// ==========================================
// register offsets
`define ISC_MSC_OFS 8'h00
`define ISC_SCALE_OFS 8'h04
`define ISC_FILT_OFS 8'h08
`define ISC_STAT_OFS 8'h0c
// ==========================================
// reset values and masks
`define ISC_MSC_RST 16'h00c1
`define ISC_MSC_WMASK 16'h03cd
`define ISC_SCALE_RST 16'h07d0
`define ISC_FILT_RST 16'h0000
// ==========================================
// field positions
`define ISC_POL_BIT 0
`define ISC_MODE_LSB 2
`define ISC_POP_BIT 6
`define ISC_LIN_BIT 7
`define ISC_FLD_LSB 6
`define ISC_Q_FRAC 14
// ==========================================
// timing and bus response codes
`define ISC_CLK_HZ 40000000
`define ISC_INT_HZ 2000
`define ISC_LOCK_US 100
`define ISC_FLD_US 200
`define ISC_RESP_OK 2'h0
`define ISC_RESP_ERR 2'h2
`endif

// ---- hdl/isc_pkg.sv ----
package isc_pkg;
  typedef enum logic [1:0] {ISC_INTERNAL, ISC_DIRECT, ISC_SCALED, ISC_OUTPUT} isc_mode_e;
  typedef logic signed [15:0] isc_smp_t;
endpackage

// ---- hdl/isc_fir.sv ----
`timescale 1ns/10ps
module isc_fir import isc_pkg::*; #(
  parameter int W = 16,
  parameter int LGMAX = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire logic signed [W-1:0] din,
  input wire logic [1:0] lg,
  output logic out_valid,
  output logic signed [W-1:0] dout
);
  localparam int N = 1 << LGMAX;
  logic signed [W-1:0] h1_r [N];
  logic signed [W-1:0] h1_nxt [N];
  logic signed [W-1:0] h2_r [N];
  logic signed [W-1:0] h2_nxt [N];
  logic signed [W-1:0] dout_r, dout_nxt;
  logic v1_r, v2_r, ov_r;
  logic signed [W+LGMAX-1:0] s1, s2;

  // ==========================================
  // two cascaded moving averages of 2**lg taps
  always_comb begin
    s1 = '0;
    s2 = '0;
    for (int i = 0; i < N; i++) begin
      if (i < (1 << lg)) begin
        s1 = s1 + h1_r[i];
        s2 = s2 + h2_r[i];
      end
    end
    for (int i = 0; i < N; i++) begin
      h1_nxt[i] = h1_r[i];
      h2_nxt[i] = h2_r[i];
    end
    if (in_valid) begin
      h1_nxt[0] = din;
      for (int i = 1; i < N; i++) h1_nxt[i] = h1_r[i-1];
    end
    if (v1_r) begin
      h2_nxt[0] = W'(s1 >>> lg);
      for (int i = 1; i < N; i++) h2_nxt[i] = h2_r[i-1];
    end
    dout_nxt = v2_r ? W'(s2 >>> lg) : dout_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N; i++) begin
        h1_r[i] <= '0;
        h2_r[i] <= '0;
      end
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      ov_r <= 1'b0;
      dout_r <= '0;
    end else begin
      h1_r <= h1_nxt;
      h2_r <= h2_nxt;
      v1_r <= in_valid;
      v2_r <= v1_r;
      ov_r <= v2_r;
      dout_r <= dout_nxt;
    end
  end

  assign out_valid = ov_r;
  assign dout = dout_r;
endmodule // isc_fir

// ---- hdl/isc_cal.sv ----
`timescale 1ns/10ps
`include "isc_map.svh"
module isc_cal import isc_pkg::*; #(
  parameter int W = 16,
  parameter logic [9*W-1:0] MG = {16'h4000, {3{16'h0000}}, 16'h4000, {3{16'h0000}}, 16'h4000},
  parameter logic [3*W-1:0] BG = '0,
  parameter logic [9*W-1:0] LM = '0,
  parameter logic [9*W-1:0] MA = {16'h4000, {3{16'h0000}}, 16'h4000, {3{16'h0000}}, 16'h4000},
  parameter logic [3*W-1:0] BA = '0,
  parameter logic [9*W-1:0] PM = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire logic lin_en,
  input wire logic pop_en,
  input wire logic [3*W-1:0] raw_g,
  input wire logic [3*W-1:0] raw_a,
  output logic out_valid,
  output logic [3*W-1:0] cal_g,
  output logic [3*W-1:0] cal_a
);
  localparam int AW = 2*W+5;
  logic signed [W-1:0] g_r [3];
  logic signed [W-1:0] a_r [3];
  logic signed [W-1:0] g_nxt [3];
  logic signed [W-1:0] a_nxt [3];
  logic ov_r;

  function automatic logic signed [W-1:0] sat(input logic signed [AW-1:0] v);
    logic signed [AW-1:0] hi;
    logic signed [AW-1:0] lo;
    hi = AW'(2**(W-1)-1);
    lo = -hi - AW'(1);
    if (v > hi) sat = hi[W-1:0];
    else if (v < lo) sat = lo[W-1:0];
    else sat = v[W-1:0];
  endfunction

  // ==========================================
  // per-axis correction; cross terms use the previous calibrated set
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic signed [AW-1:0] sg, sl, sa, sp;
    logic [2*W-1:0] sq;
    always_comb begin
      sg = '0;
      sl = '0;
      sa = '0;
      sp = '0;
      sq = '0;
      for (int j = 0; j < 3; j++) begin
        sg = sg + $signed(MG[(i*3+j)*W +: W]) * $signed(raw_g[j*W +: W]);
        sl = sl + $signed(LM[(i*3+j)*W +: W]) * a_r[j];
        sa = sa + $signed(MA[(i*3+j)*W +: W]) * $signed(raw_a[j*W +: W]);
        sq = (2*W)'(g_r[j] * g_r[j]);
        if (j != i) sp = sp + $signed(PM[(i*3+j)*W +: W]) * $signed({1'b0, sq[2*W-1:W]});
      end
      if (!lin_en) sl = '0; // R16
      if (!pop_en) sp = '0; // R18
      g_nxt[i] = sat(((sg + sl) >>> `ISC_Q_FRAC) + $signed(BG[i*W +: W])); // R15
      a_nxt[i] = sat(((sa + sp) >>> `ISC_Q_FRAC) + $signed(BA[i*W +: W])); // R17
    end
    assign cal_g[i*W +: W] = g_r[i];
    assign cal_a[i*W +: W] = a_r[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        g_r[i] <= '0;
        a_r[i] <= '0;
      end
      ov_r <= 1'b0;
    end else begin
      if (in_valid) begin
        g_r <= g_nxt;
        a_r <= a_nxt;
      end
      ov_r <= in_valid;
    end
  end

  assign out_valid = ov_r;
endmodule // isc_cal

// ---- hdl/isc_clk_ctrl.sv ----
`timescale 1ns/10ps
`include "isc_map.svh"
// How it works
// R1 - two-bit field [3:2] picks clock source
// R2 - 00 internal 2000 Hz clock, default
// R3 - 01 sample on external timing pin edge
// R4 - host supplies 1900 to 2100 Hz
// R5 - 10 scaled mode, 1 to 128 Hz
// R6 - sample rate is external times multiplier
// R7 - multiplier change resets and relocks loop
// R8 - reference edge resets feedback; lock within 100us
// R9 - 11 internal clock, pulse timing pin
// R10 - mode and multiplier readback after reconfiguration
// R11 - host waits data ready before verifying
// R12 - bits [9:6] readback within 200us
// R13 - external clock present two cycles
// R14 - two cascaded averaging FIR stages
// R15 - gyro matrix, bias, acceleration term
// R16 - bit 7 gates linear acceleration term
// R17 - accel matrix, bias, squared gyro term
// R18 - bit 6 gates percussion term
// R19 - coefficients fixed, not user accessible
// R20 - runs at 2000 SPS after reset
// R21 - data ready pulses per output update
// R22 - one timing pulse per internal sample
module isc_clk_ctrl import isc_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int INT_DIV = `ISC_CLK_HZ / `ISC_INT_HZ,
  parameter int FLD_CYC = `ISC_FLD_US * (`ISC_CLK_HZ / 1000000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_n,
  output logic data_ready_output,
  output logic sample_strobe,
  input wire logic [15:0] raw_gx,
  input wire logic [15:0] raw_gy,
  input wire logic [15:0] raw_gz,
  input wire logic [15:0] raw_ax,
  input wire logic [15:0] raw_ay,
  input wire logic [15:0] raw_az,
  output logic [15:0] out_gx,
  output logic [15:0] out_gy,
  output logic [15:0] out_gz,
  output logic [15:0] out_ax,
  output logic [15:0] out_ay,
  output logic [15:0] out_az
);
  localparam int LOCK_CYC = `ISC_LOCK_US * (`ISC_CLK_HZ / 1000000);
  localparam int DW = $clog2(INT_DIV + 1);
  localparam int FW = $clog2(FLD_CYC + 1);
  localparam int PW = 27;

  // ==========================================
  // axi4-lite slave
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_wr, wr_msc, wr_scale, wr_filt, rd_hit, wr_hit;
  logic [15:0] msc_rd, scale_rd, filt_rd, stat_rd;

  assign awready = ~aw_hold_r & ~bvalid_r;
  assign wready = ~w_hold_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_msc = do_wr & (awa_r == ADDR_W'(`ISC_MSC_OFS));
  assign wr_scale = do_wr & (awa_r == ADDR_W'(`ISC_SCALE_OFS));
  assign wr_filt = do_wr & (awa_r == ADDR_W'(`ISC_FILT_OFS));
  assign wr_hit = wr_msc | wr_scale | wr_filt | (awa_r == ADDR_W'(`ISC_STAT_OFS));

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bvalid_nxt = bvalid_r & ~bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r & ~rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    rd_hit = 1'b1;
    if (awvalid & awready) begin
      aw_hold_nxt = 1'b1;
      awa_nxt = awaddr;
    end
    if (wvalid & wready) begin
      w_hold_nxt = 1'b1;
      wd_nxt = wdata;
      ws_nxt = wstrb;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `ISC_RESP_OK : `ISC_RESP_ERR;
    end
    if (arvalid & arready) begin
      unique case (araddr)
        ADDR_W'(`ISC_MSC_OFS): rdata_nxt = {16'h0000, msc_rd};
        ADDR_W'(`ISC_SCALE_OFS): rdata_nxt = {16'h0000, scale_rd};
        ADDR_W'(`ISC_FILT_OFS): rdata_nxt = {16'h0000, filt_rd};
        ADDR_W'(`ISC_STAT_OFS): rdata_nxt = {16'h0000, stat_rd};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rd_hit = 1'b0;
        end
      endcase
      rvalid_nxt = 1'b1;
      rresp_nxt = rd_hit ? `ISC_RESP_OK : `ISC_RESP_ERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awa_r <= '0;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `ISC_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r <= `ISC_RESP_OK;
      rdata_r <= 32'h0000_0000;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // ==========================================
  // configuration, delayed readback
  logic [15:0] msc_r, msc_nxt, scale_pend_r, scale_pend_nxt, scale_act_r, scale_act_nxt;
  logic [15:0] filt_r, filt_nxt, wmask;
  logic [3:0] fld_vis_r, fld_vis_nxt;
  logic [FW-1:0] fld_cnt_r, fld_cnt_nxt;
  isc_mode_e mode_act_r, mode_act_nxt;
  logic int_tick, pll_rst, lock_r, per_ok;

  assign wmask = {{8{ws_r[1]}}, {8{ws_r[0]}}};

  always_comb begin
    msc_nxt = msc_r;
    scale_pend_nxt = scale_pend_r;
    filt_nxt = filt_r;
    mode_act_nxt = mode_act_r;
    scale_act_nxt = scale_act_r;
    fld_vis_nxt = fld_vis_r;
    fld_cnt_nxt = fld_cnt_r;
    if (wr_msc) msc_nxt = (msc_r & ~(wmask & `ISC_MSC_WMASK)) | (wd_r[15:0] & wmask & `ISC_MSC_WMASK);
    if (wr_scale) scale_pend_nxt = (scale_pend_r & ~wmask) | (wd_r[15:0] & wmask);
    if (wr_filt) filt_nxt = (filt_r & ~wmask) | (wd_r[15:0] & wmask);
    if (int_tick) begin
      mode_act_nxt = isc_mode_e'(msc_r[`ISC_MODE_LSB +: 2]); // R1 R10
      scale_act_nxt = scale_pend_r; // R10
    end
    if (wr_msc) fld_cnt_nxt = FW'(FLD_CYC); // R12
    else if (fld_cnt_r != '0) begin
      fld_cnt_nxt = fld_cnt_r - FW'(1);
      if (fld_cnt_r == FW'(1)) fld_vis_nxt = msc_r[`ISC_FLD_LSB +: 4]; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msc_r <= `ISC_MSC_RST;
      scale_pend_r <= `ISC_SCALE_RST;
      scale_act_r <= `ISC_SCALE_RST;
      filt_r <= `ISC_FILT_RST;
      mode_act_r <= ISC_INTERNAL; // R2 R20
      fld_vis_r <= 4'h3;
      fld_cnt_r <= '0;
    end else begin
      msc_r <= msc_nxt;
      scale_pend_r <= scale_pend_nxt;
      scale_act_r <= scale_act_nxt;
      filt_r <= filt_nxt;
      mode_act_r <= mode_act_nxt;
      fld_vis_r <= fld_vis_nxt;
      fld_cnt_r <= fld_cnt_nxt;
    end
  end

  assign pll_rst = int_tick & (scale_pend_r != scale_act_r); // R7
  assign msc_rd = {msc_r[15:10], fld_vis_r, msc_r[5:4], 2'(mode_act_r), msc_r[1:0]}; // R10 R12
  assign scale_rd = scale_act_r; // R10
  assign filt_rd = filt_r;
  assign stat_rd = {12'h000, 2'(mode_act_r), per_ok, lock_r};

  // ==========================================
  // sample clock sources
  logic s1_r, s2_r, s3_r, rise;
  logic [DW-1:0] int_cnt_r, int_cnt_nxt;
  logic [PW-1:0] per_cnt_r, per_cnt_nxt, per_r, per_nxt;
  logic [PW:0] acc_r, acc_nxt, acc_sum;
  logic [1:0] edges_r, edges_nxt;
  logic [15:0] fbn_r, fbn_nxt;
  logic [12:0] sk_r, sk_nxt;
  logic lock_nxt, fb_tick, smp_tick;

  assign rise = s2_r & ~s3_r;
  assign int_tick = (int_cnt_r == DW'(INT_DIV - 1));
  assign per_ok = (edges_r == 2'h2); // R13
  assign acc_sum = acc_r + (PW+1)'(scale_act_r);

  always_comb begin
    int_cnt_nxt = int_tick ? '0 : int_cnt_r + DW'(1); // R2
    per_cnt_nxt = (&per_cnt_r) ? per_cnt_r : per_cnt_r + PW'(1);
    per_nxt = per_r;
    edges_nxt = edges_r;
    acc_nxt = acc_r;
    fbn_nxt = fbn_r;
    sk_nxt = (&sk_r) ? sk_r : sk_r + 13'h0001;
    lock_nxt = lock_r;
    fb_tick = 1'b0;
    if (per_ok && scale_act_r != 16'h0000) begin
      if (acc_sum >= {1'b0, per_r}) begin
        acc_nxt = acc_sum - {1'b0, per_r}; // R6
        fb_tick = 1'b1;
        fbn_nxt = (&fbn_r) ? fbn_r : fbn_r + 16'h0001;
        if (fbn_r + 16'h0001 == scale_act_r) sk_nxt = 13'h0000;
      end else acc_nxt = acc_sum;
    end
    if (rise) begin
      per_cnt_nxt = '0;
      per_nxt = per_cnt_r + PW'(1);
      if (!per_ok) edges_nxt = edges_r + 2'h1;
      lock_nxt = per_ok && (fbn_nxt == scale_act_r) && (sk_nxt <= 13'(LOCK_CYC)); // R8
      acc_nxt = '0; // R8
      fbn_nxt = 16'h0000;
    end
    if (pll_rst) begin
      lock_nxt = 1'b0; // R7
      acc_nxt = '0;
      fbn_nxt = 16'h0000;
    end
    if (mode_act_r != ISC_SCALED && mode_act_r != ISC_DIRECT) edges_nxt = 2'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      int_cnt_r <= '0;
      per_cnt_r <= '0;
      per_r <= '0;
      edges_r <= 2'h0;
      acc_r <= '0;
      fbn_r <= 16'h0000;
      sk_r <= 13'h1fff;
      lock_r <= 1'b0;
    end else begin
      s1_r <= sync_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      int_cnt_r <= int_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      per_r <= per_nxt;
      edges_r <= edges_nxt;
      acc_r <= acc_nxt;
      fbn_r <= fbn_nxt;
      sk_r <= sk_nxt;
      lock_r <= lock_nxt;
    end
  end

  always_comb begin
    unique case (mode_act_r)
      ISC_INTERNAL: smp_tick = int_tick; // R2
      ISC_DIRECT: smp_tick = rise; // R3
      ISC_SCALED: smp_tick = fb_tick; // R5 R6
      ISC_OUTPUT: smp_tick = int_tick; // R9
    endcase
  end

  // ==========================================
  // sample path, outputs
  logic [47:0] cal_g, cal_a;
  logic [95:0] cal_all;
  logic [95:0] fir_out;
  logic [5:0] fir_v;
  logic cal_v, smp_r, sync_o_r, oe_n_r, rdy_r, rdy_nxt;
  logic [15:0] out_r [6];

  isc_cal u_cal (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(smp_tick),
    .lin_en(msc_r[`ISC_LIN_BIT]), // R16 R19
    .pop_en(msc_r[`ISC_POP_BIT]), // R18
    .raw_g({raw_gz, raw_gy, raw_gx}),
    .raw_a({raw_az, raw_ay, raw_ax}),
    .out_valid(cal_v),
    .cal_g(cal_g),
    .cal_a(cal_a)
  );

  assign cal_all = {cal_a, cal_g};

  for (genvar c = 0; c < 6; c++) begin : g_fir
    isc_fir u_fir (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(cal_v),
      .din(cal_all[c*16 +: 16]), // R14
      .lg(filt_r[1:0]),
      .out_valid(fir_v[c]),
      .dout(fir_out[c*16 +: 16])
    );
  end

  always_comb begin
    rdy_nxt = msc_r[`ISC_POL_BIT] ? fir_v[0] : ~fir_v[0]; // R21
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_r <= 1'b0;
      sync_o_r <= 1'b0;
      oe_n_r <= 1'b1;
      rdy_r <= 1'b0;
      for (int c = 0; c < 6; c++) out_r[c] <= 16'h0000;
    end else begin
      smp_r <= smp_tick;
      sync_o_r <= (mode_act_r == ISC_OUTPUT) & int_tick; // R9 R22
      oe_n_r <= (mode_act_r != ISC_OUTPUT); // R3 R9
      rdy_r <= rdy_nxt;
      if (fir_v[0]) begin
        for (int c = 0; c < 6; c++) out_r[c] <= fir_out[c*16 +: 16]; // R20 R21
      end
    end
  end

  assign sample_strobe = smp_r;
  assign sync_o = sync_o_r;
  assign sync_oe_n = oe_n_r;
  assign data_ready_output = rdy_r;
  assign {out_gx, out_gy, out_gz} = {out_r[0], out_r[1], out_r[2]};
  assign {out_ax, out_ay, out_az} = {out_r[3], out_r[4], out_r[5]};
endmodule // isc_clk_ctrl

// ---- testbench/isc_clk_ctrl_monitor.sv ----
`timescale 1ns/10ps
// ==========================================
// port checks for the clock control block
module isc_clk_ctrl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic sync_o,
  input wire logic sync_oe_n,
  input wire logic data_ready_output,
  input wire logic sample_strobe
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response not held");

  property p_b_lat;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write response late");

  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while answer pending");

  property p_oe_drv;
    sync_o |-> !sync_oe_n;
  endproperty
  a_oe_drv: assert property (p_oe_drv)
    else $error("timing pin pulsed while not driven");

  property p_out_align;
    sync_o |-> sample_strobe ##1 !sync_o;
  endproperty
  a_out_align: assert property (p_out_align)
    else $error("timing pulse not one cycle with the sample");

  property p_dr_lat;
    sample_strobe |-> ##4 !$stable(data_ready_output);
  endproperty
  a_dr_lat: assert property (p_dr_lat)
    else $error("data ready missing after sample");

  property p_dr_cause;
    !$stable(data_ready_output) |-> $past(sample_strobe, 4) || $past(sample_strobe, 5);
  endproperty
  a_dr_cause: assert property (p_dr_cause)
    else $error("data ready moved without a sample");

  property p_strobe_one;
    sample_strobe |=> !sample_strobe;
  endproperty
  a_strobe_one: assert property (p_strobe_one)
    else $error("sample strobe longer than one cycle");
endmodule // isc_clk_ctrl_monitor

bind isc_clk_ctrl isc_clk_ctrl_monitor i_isc_clk_ctrl_monitor (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .sync_o(sync_o), .sync_oe_n(sync_oe_n), .data_ready_output(data_ready_output),
  .sample_strobe(sample_strobe)
);

// ---- testbench/isc_sync_src.sv ----
`timescale 1ns/10ps
// ==========================================
// external timing source, unrelated to the bench clock
module isc_sync_src (
  input wire logic en,
  input wire logic [15:0] half_ns,
  output logic ext
);
  // runs whole periods only, stands low when off
  always begin
    if (en) begin
      #(half_ns) ext = 1'h1;
      #(half_ns) ext = 1'h0;
    end else begin
      #7 ext = 1'h0;
    end
  end
endmodule // isc_sync_src

// ---- testbench/isc_clk_ctrl_bench.sv ----
`timescale 1ns/10ps
module isc_clk_ctrl_bench import isc_pkg::*;;
  typedef struct {
    logic we;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
  } isc_row_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, pin, ext, en, sync_o, sync_oe_n, data_ready_output, sample_strobe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] bresp, rresp, r;
  logic [15:0] half_ns;
  logic [15:0] raw [6];
  logic [15:0] outv [6];
  int miscompares, n_tests, k;
  isc_row_s rows [10] = '{
    '{1'h0, 8'h00, 32'h0, 32'h00c1, 2'h0},
    '{1'h0, 8'h04, 32'h0, 32'h07d0, 2'h0},
    '{1'h0, 8'h08, 32'h0, 32'h0, 2'h0},
    '{1'h0, 8'h0c, 32'h0, 32'h0, 2'h0},
    '{1'h0, 8'h10, 32'h0, 32'h0, 2'h2},
    '{1'h1, 8'h0c, 32'h5, 32'h0, 2'h0},
    '{1'h0, 8'h0c, 32'h0, 32'h0, 2'h0},
    '{1'h1, 8'h10, 32'h5, 32'h0, 2'h2},
    '{1'h1, 8'h08, 32'h3, 32'h0, 2'h0},
    '{1'h0, 8'h08, 32'h0, 32'h3, 2'h0}
  };

  // timing pin level from both drivers
  assign pin = sync_oe_n ? ext : sync_o;

  isc_sync_src i_isc_sync_src (.en(en), .half_ns(half_ns), .ext(ext));

  isc_clk_ctrl #(.INT_DIV(20), .FLD_CYC(8)) i_isc_clk_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sync_i(pin),
    .sync_o(sync_o), .sync_oe_n(sync_oe_n), .data_ready_output(data_ready_output),
    .sample_strobe(sample_strobe), .raw_gx(raw[0]), .raw_gy(raw[1]), .raw_gz(raw[2]),
    .raw_ax(raw[3]), .raw_ay(raw[4]), .raw_az(raw[5]), .out_gx(outv[0]), .out_gy(outv[1]),
    .out_gz(outv[2]), .out_ax(outv[3]), .out_ay(outv[4]), .out_az(outv[5])
  );

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================
  // helpers
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("unexpected wait: expected %0d seen %0d", lim, n);
      final_report();
    end
  endtask

  // ready is raised only after the answer is seen
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    if (we) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
    end else begin
      araddr <= a;
      arvalid <= 1'h1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      if (bready && bvalid === 1'h1) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
      if (rready && rvalid === 1'h1) begin
        q = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
      if (bvalid === 1'h1) bready <= 1'h1;
      if (rvalid === 1'h1) rready <= 1'h1;
    end
    guard(n, 50);
    @(posedge aclk);
  endtask

  task automatic strobe(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      guard(n, 100);
    end while (sample_strobe !== 1'h1);
  endtask

  // counts samples up to the next rising edge of the pin
  task automatic sync_edge(output int c);
    int n;
    logic p;
    c = 0;
    p = 1'h1;
    for (n = 0; n < 3000; n++) begin
      @(posedge aclk);
      if (sample_strobe === 1'h1) c++;
      if (pin === 1'h1 && !p) break;
      p = pin;
    end
    guard(n, 3000);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, en} = 7'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    half_ns = 16'h0178;
    foreach (raw[i]) raw[i] = 16'h0111 * 16'(i + 1);
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) chk("rdata", rows[i].q, q);
      chk("resp", {30'h0, rows[i].r}, {30'h0, r});
    end
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("reset", 32'h2, {27'h0, bvalid, rvalid, sync_o, sync_oe_n, data_ready_output});
    aresetn <= 1'h1;
    @(posedge aclk);
    bus(1'h0, 8'h08, 32'h0);
    chk("filter", 32'h0, q);
    bus(1'h1, 8'h08, 32'h3);
    strobe(k);
    strobe(k);
    chk("period", 32'h14, 32'(k));
    repeat (4) @(posedge aclk);
    chk("ready", 32'h1, {31'h0, data_ready_output});
    bus(1'h1, 8'h00, 32'h0301);
    bus(1'h0, 8'h00, 32'h0);
    chk("field", 32'h00c1, q);
    repeat (8) @(posedge aclk);
    bus(1'h0, 8'h00, 32'h0);
    chk("field", 32'h0301, q);
    strobe(k);
    bus(1'h1, 8'h00, 32'h030d);
    bus(1'h0, 8'h00, 32'h0);
    chk("mode", 32'h0301, q);
    strobe(k);
    bus(1'h0, 8'h00, 32'h0);
    chk("mode", 32'h030d, q);
    sync_edge(k);
    sync_edge(k);
    chk("pulses", 32'h1, 32'(k));
    chk("drive", 32'h0, {31'h0, sync_oe_n});
    en <= 1'h1;
    bus(1'h1, 8'h00, 32'h0305);
    for (int i = 0; i < 4; i++) sync_edge(k);
    chk("direct", 32'h1, 32'(k));
    chk("input", 32'h1, {31'h0, sync_oe_n});
    bus(1'h0, 8'h0c, 32'h0);
    chk("status", 32'h6, q & 32'he);
    half_ns <= 16'h1388;
    bus(1'h1, 8'h04, 32'h4);
    bus(1'h1, 8'h00, 32'h0309);
    for (int i = 0; i < 6; i++) sync_edge(k);
    chk("scaled", 32'h4, 32'(k));
    bus(1'h0, 8'h0c, 32'h0);
    chk("lock", 32'hb, q & 32'hf);
    sync_edge(k);
    bus(1'h1, 8'h04, 32'h8);
    repeat (25) @(posedge aclk);
    bus(1'h0, 8'h0c, 32'h0);
    chk("relock", 32'h0, q & 32'h1);
    bus(1'h0, 8'h04, 32'h0);
    chk("scale", 32'h8, q);
    for (int i = 0; i < 6; i++) sync_edge(k);
    chk("scaled", 32'h8, 32'(k));
    bus(1'h0, 8'h0c, 32'h0);
    chk("lock", 32'hb, q & 32'hf);
    foreach (outv[i]) chk("sample", {16'h0, raw[i]}, {16'h0, outv[i]});
    final_report();
  end
endmodule // isc_clk_ctrl_bench
